// *** design/via_params.svh ***
// constants of the vectored interrupt acknowledge block
`ifndef VIA_PARAMS_SVH
`define VIA_PARAMS_SVH

// ----------------------------------------
// status word fields and reset value
// ----------------------------------------
`define VIA_PSW_IE_BIT 7
`define VIA_PSW_ISP_BIT 1
`define VIA_PSW_RESET 8'h02

// ----------------------------------------
// vectors
// ----------------------------------------
`define VIA_TRAP_VECTOR 16'h003e
`define VIA_VEC_BASE 16'h0004

// ----------------------------------------
// flag register selectors for writes
// ----------------------------------------
`define VIA_SEL_REQUEST 2'h0
`define VIA_SEL_MASK 2'h1
`define VIA_SEL_LEVEL 2'h2

// ----------------------------------------
// acknowledge latency in clocks, clock period in ns and age counter width
// ----------------------------------------
`define VIA_CLK_PERIOD_NS 10
`define VIA_MIN_LAT_HIGH 7
`define VIA_MIN_LAT_LOW 8
`define VIA_MAX_LAT_HIGH 32
`define VIA_MAX_LAT_LOW 33
`define VIA_AGE_W 4

`endif

// *** design/via_pkg.sv ***
// types of the vectored interrupt acknowledge block
package via_pkg;

    // service sequence states, gray coded along the path
    typedef enum logic [1:0] {
        VIA_IDLE = 2'h0,
        VIA_PUSH_PSW = 2'h1,
        VIA_PUSH_PC = 2'h3,
        VIA_LOAD_VEC = 2'h2
    } via_state_t;

endpackage

// *** design/via_age.sv ***
// per-source age counters since request generation
`timescale 1ns/100ps
`include "via_params.svh"

module via_age
    import via_pkg::*;
#(
    parameter int N = 16
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [N-1:0] src_req,
    output logic [N*`VIA_AGE_W-1:0] age
);

    // ----------------------------------------
    // saturating counters, restarted by each new request
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < N; g = g + 1) begin : g_age
            logic [`VIA_AGE_W-1:0] cnt_r;
            logic [`VIA_AGE_W-1:0] cnt_nxt;
            // saturate so an old request stays old forever
            always_comb begin
                cnt_nxt = cnt_r;
                if (src_req[g]) begin
                    cnt_nxt = {{(`VIA_AGE_W-1){1'b0}}, 1'b1};
                end else if (cnt_r != {`VIA_AGE_W{1'b1}}) begin
                    cnt_nxt = cnt_r + {{(`VIA_AGE_W-1){1'b0}}, 1'b1};
                end
            end
            // starts saturated: nothing recent after reset
            always_ff @(posedge core_clk or negedge resetn) begin
                if (!resetn) begin
                    cnt_r <= {`VIA_AGE_W{1'b1}};
                end else begin
                    cnt_r <= cnt_nxt;
                end
            end
            assign age[g*`VIA_AGE_W +: `VIA_AGE_W] = cnt_r;
        end
    endgenerate

endmodule

// *** design/via_pick.sv ***
// priority pick among acknowledgeable requests
`timescale 1ns/100ps

module via_pick
    import via_pkg::*;
#(
    parameter int N = 16,
    parameter int IDX_W = $clog2(N)
) (
    input wire logic [N-1:0] cand,
    input wire logic [N-1:0] level,
    output logic found,
    output logic [IDX_W-1:0] idx
);

    // lowest index wins: it has the highest default priority
    function automatic logic [IDX_W:0] first_set(input logic [N-1:0] v);
        logic [IDX_W:0] res;
        res = '0;
        for (int i = N - 1; i >= 0; i = i - 1) begin
            if (v[i]) begin
                res = {1'b1, IDX_W'(i)};
            end
        end
        return res;
    endfunction

    logic [IDX_W:0] hi_pick;
    logic [IDX_W:0] lo_pick;

    // ----------------------------------------
    // high level group first, then low level group
    // ----------------------------------------
    always_comb begin
        hi_pick = first_set(cand & ~level);
        lo_pick = first_set(cand & level);
        found = hi_pick[IDX_W] | lo_pick[IDX_W];
        idx = hi_pick[IDX_W] ? hi_pick[IDX_W-1:0] : lo_pick[IDX_W-1:0];
    end

endmodule

// *** design/via_top.sv ***
// vectored interrupt acknowledge: flags, status word, take decision and stacking
`timescale 1ns/100ps
`include "via_params.svh"

module via_top
    import via_pkg::*;
#(
    parameter int N = 16,
    parameter logic [N-1:0] CLEAR_ON_TAKE = '0,
    parameter logic [15:0] VEC_BASE = `VIA_VEC_BASE,
    parameter int IDX_W = $clog2(N)
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [N-1:0] src_req,
    input wire logic flag_wr_en,
    input wire logic [1:0] flag_wr_sel,
    input wire logic [N-1:0] flag_wr_mask,
    input wire logic [N-1:0] flag_wr_data,
    input wire logic psw_wr_en,
    input wire logic [7:0] psw_wr_mask,
    input wire logic [7:0] psw_wr_data,
    input wire logic psw_restore_en,
    input wire logic [7:0] psw_restore_data,
    input wire logic enable_all_op,
    input wire logic mask_all_op,
    input wire logic trap_op,
    input wire logic instr_boundary,
    input wire logic instr_hold,
    input wire logic div_busy,
    input wire logic [15:0] cur_pc,
    output logic [N-1:0] request_flag,
    output logic [N-1:0] mask_flag,
    output logic [N-1:0] level_select_flag,
    output logic [7:0] processor_status_word,
    output logic svc_busy,
    output logic take_pulse,
    output logic take_is_trap,
    output logic [IDX_W-1:0] take_index,
    output logic stack_push_en,
    output logic stack_push_is_pc,
    output logic [15:0] stack_push_data,
    output logic vector_load_en,
    output logic [15:0] vector_addr
);

    // ----------------------------------------
    // latency thresholds on the age counters
    // ----------------------------------------
    // the take decision is one cycle before the take pulse, hence the minus one
    localparam logic [`VIA_AGE_W-1:0] AGE_MIN_HIGH = `VIA_AGE_W'(`VIA_MIN_LAT_HIGH - 1);
    localparam logic [`VIA_AGE_W-1:0] AGE_MIN_LOW = `VIA_AGE_W'(`VIA_MIN_LAT_LOW - 1);

    logic [N-1:0] req_r, req_nxt;
    logic [N-1:0] mask_r, mask_nxt;
    logic [N-1:0] lvl_r, lvl_nxt;
    logic [7:0] psw_r, psw_nxt;
    via_state_t state_r, state_nxt;
    logic trap_r, trap_nxt;
    logic [IDX_W-1:0] idx_r, idx_nxt;
    logic [15:0] pc_r, pc_nxt;
    logic [7:0] saved_psw_r, saved_psw_nxt;
    logic take_r, take_nxt;
    logic push_en_r, push_en_nxt;
    logic push_pc_r, push_pc_nxt;
    logic [15:0] push_data_r, push_data_nxt;
    logic vec_en_r, vec_en_nxt;
    logic [15:0] vec_r, vec_nxt;
    logic busy_r, busy_nxt;
    logic lvl_taken_r, lvl_taken_nxt;

    logic [N*`VIA_AGE_W-1:0] age;
    logic [N-1:0] aged;
    logic [N-1:0] cand;
    logic pick_found;
    logic [IDX_W-1:0] pick_idx;
    logic decide;
    logic take_mask;
    logic take_trap;

    via_age #(
        .N(N)
    ) u_age (
        .core_clk(core_clk),
        .resetn(resetn),
        .src_req(src_req),
        .age(age)
    );

    // ----------------------------------------
    // eligibility of each source
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < N; g = g + 1) begin : g_cand
            assign aged[g] = age[g*`VIA_AGE_W +: `VIA_AGE_W] >= (lvl_r[g] ? AGE_MIN_LOW : AGE_MIN_HIGH);
            // level 1 is low priority and is blocked while a high handler runs
            assign cand[g] = req_r[g] & ~mask_r[g] & aged[g] & (psw_r[`VIA_PSW_ISP_BIT] | ~lvl_r[g]);
        end
    endgenerate

    via_pick #(
        .N(N),
        .IDX_W(IDX_W)
    ) u_pick (
        .cand(cand),
        .level(lvl_r),
        .found(pick_found),
        .idx(pick_idx)
    );

    // ----------------------------------------
    // take decision at an instruction boundary
    // ----------------------------------------
    // a hold instruction defers to the next boundary, which also makes a return
    // let one interrupted-program instruction run before a pending request is taken
    always_comb begin
        decide = instr_boundary & ~div_busy & (state_r == VIA_IDLE);
        take_trap = decide & trap_op;
        take_mask = decide & ~trap_op & ~instr_hold & psw_r[`VIA_PSW_IE_BIT] & pick_found;
    end

    // ----------------------------------------
    // flag registers: next values
    // ----------------------------------------
    // a request arriving in the clearing cycle wins over the clear
    always_comb begin
        req_nxt = req_r;
        mask_nxt = mask_r;
        lvl_nxt = lvl_r;
        if (flag_wr_en && flag_wr_sel == `VIA_SEL_REQUEST) begin
            req_nxt = (req_r & ~flag_wr_mask) | (flag_wr_data & flag_wr_mask);
        end else if (flag_wr_en && flag_wr_sel == `VIA_SEL_MASK) begin
            mask_nxt = (mask_r & ~flag_wr_mask) | (flag_wr_data & flag_wr_mask);
        end else if (flag_wr_en && flag_wr_sel == `VIA_SEL_LEVEL) begin
            lvl_nxt = (lvl_r & ~flag_wr_mask) | (flag_wr_data & flag_wr_mask);
        end
        if (take_mask && CLEAR_ON_TAKE[pick_idx]) begin
            req_nxt[pick_idx] = 1'b0;
        end
        req_nxt = req_nxt | src_req;
    end

    // masks and levels start all ones: masked and low priority
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            req_r <= '0;
            mask_r <= '1;
            lvl_r <= '1;
        end else begin
            req_r <= req_nxt;
            mask_r <= mask_nxt;
            lvl_r <= lvl_nxt;
        end
    end

    // ----------------------------------------
    // status word: next value
    // ----------------------------------------
    // later steps win: restore, write, enable/mask op, then the take itself
    always_comb begin
        psw_nxt = psw_r;
        if (psw_restore_en) begin
            psw_nxt = psw_restore_data;
        end
        if (psw_wr_en) begin
            psw_nxt = (psw_nxt & ~psw_wr_mask) | (psw_wr_data & psw_wr_mask);
        end
        if (enable_all_op) begin
            psw_nxt[`VIA_PSW_IE_BIT] = 1'b1;
        end else if (mask_all_op) begin
            psw_nxt[`VIA_PSW_IE_BIT] = 1'b0;
        end
        if (take_mask || take_trap) begin
            psw_nxt[`VIA_PSW_IE_BIT] = 1'b0;
        end
        if (take_mask) begin
            psw_nxt[`VIA_PSW_ISP_BIT] = lvl_r[pick_idx];
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            psw_r <= `VIA_PSW_RESET;
        end else begin
            psw_r <= psw_nxt;
        end
    end

    // ----------------------------------------
    // service sequence: push status, push pc, load vector
    // ----------------------------------------
    always_comb begin
        state_nxt = state_r;
        trap_nxt = trap_r;
        idx_nxt = idx_r;
        pc_nxt = pc_r;
        saved_psw_nxt = saved_psw_r;
        lvl_taken_nxt = lvl_taken_r;
        take_nxt = 1'b0;
        push_en_nxt = 1'b0;
        push_pc_nxt = 1'b0;
        push_data_nxt = push_data_r;
        vec_en_nxt = 1'b0;
        vec_nxt = vec_r;
        case (state_r)
            VIA_IDLE: begin
                if (take_mask || take_trap) begin
                    // the stacked status is the one before accept is cleared
                    state_nxt = VIA_PUSH_PSW;
                    trap_nxt = take_trap;
                    idx_nxt = take_trap ? idx_r : pick_idx;
                    lvl_taken_nxt = take_trap ? lvl_taken_r : lvl_r[pick_idx];
                    pc_nxt = cur_pc;
                    saved_psw_nxt = psw_r;
                    take_nxt = 1'b1;
                    push_en_nxt = 1'b1;
                    push_data_nxt = {8'h00, psw_r};
                end
            end
            VIA_PUSH_PSW: begin
                state_nxt = VIA_PUSH_PC;
                push_en_nxt = 1'b1;
                push_pc_nxt = 1'b1;
                push_data_nxt = pc_r;
            end
            VIA_PUSH_PC: begin
                state_nxt = VIA_LOAD_VEC;
                vec_en_nxt = 1'b1;
                vec_nxt = trap_r ? `VIA_TRAP_VECTOR : VEC_BASE + {{(15 - IDX_W){1'b0}}, idx_r, 1'b0};
            end
            VIA_LOAD_VEC: begin
                state_nxt = VIA_IDLE;
            end
            default: begin
                state_nxt = VIA_IDLE;
            end
        endcase
        busy_nxt = (state_nxt != VIA_IDLE);
    end

    // sequence registers; the outputs below from svc_busy onward come from them, the flag and status outputs from their own registers
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state_r <= VIA_IDLE;
            trap_r <= 1'b0;
            idx_r <= '0;
            pc_r <= 16'h0000;
            saved_psw_r <= 8'h00;
            lvl_taken_r <= 1'b1;
            take_r <= 1'b0;
            push_en_r <= 1'b0;
            push_pc_r <= 1'b0;
            push_data_r <= 16'h0000;
            vec_en_r <= 1'b0;
            vec_r <= 16'h0000;
            busy_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            trap_r <= trap_nxt;
            idx_r <= idx_nxt;
            pc_r <= pc_nxt;
            saved_psw_r <= saved_psw_nxt;
            lvl_taken_r <= lvl_taken_nxt;
            take_r <= take_nxt;
            push_en_r <= push_en_nxt;
            push_pc_r <= push_pc_nxt;
            push_data_r <= push_data_nxt;
            vec_en_r <= vec_en_nxt;
            vec_r <= vec_nxt;
            busy_r <= busy_nxt;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign request_flag = req_r;
    assign mask_flag = mask_r;
    assign level_select_flag = lvl_r;
    assign processor_status_word = psw_r;
    assign svc_busy = busy_r;
    assign take_pulse = take_r;
    assign take_is_trap = trap_r;
    assign take_index = idx_r;
    assign stack_push_en = push_en_r;
    assign stack_push_is_pc = push_pc_r;
    assign stack_push_data = push_data_r;
    assign vector_load_en = vec_en_r;
    assign vector_addr = vec_r;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    AST_NEED_ACCEPT: assert property (@(posedge core_clk) disable iff (!resetn)
        take_r && !trap_r |-> $past(psw_r[`VIA_PSW_IE_BIT])) else $error("maskable take without accept");
    AST_ACCEPT_CLEARED: assert property (@(posedge core_clk) disable iff (!resetn)
        take_r |-> !psw_r[`VIA_PSW_IE_BIT]) else $error("accept not cleared on take");
    AST_STACK_ORDER: assert property (@(posedge core_clk) disable iff (!resetn)
        take_r |-> stack_push_en && !stack_push_is_pc && stack_push_data[7:0] == saved_psw_r
        ##1 stack_push_en && stack_push_is_pc && stack_push_data == pc_r ##1 vector_load_en)
        else $error("stacking order wrong");
    AST_TRAP_VECTOR: assert property (@(posedge core_clk) disable iff (!resetn)
        vector_load_en && trap_r |-> vector_addr == `VIA_TRAP_VECTOR) else $error("trap vector wrong");
    AST_LEVEL_COPY: assert property (@(posedge core_clk) disable iff (!resetn)
        take_r && !trap_r |-> psw_r[`VIA_PSW_ISP_BIT] == lvl_taken_r) else $error("level not copied");
    AST_LOW_BLOCKED: assert property (@(posedge core_clk) disable iff (!resetn)
        take_r && !trap_r && lvl_taken_r |-> $past(psw_r[`VIA_PSW_ISP_BIT])) else $error("low taken in high handler");
    AST_HOLD_DEFERS: assert property (@(posedge core_clk) disable iff (!resetn)
        instr_boundary && instr_hold && !trap_op |=> !take_r) else $error("take after hold instruction");
    AST_MIN_LATENCY: assert property (@(posedge core_clk) disable iff (!resetn)
        src_req[0] && !lvl_r[0] |=> !(take_r && !trap_r && idx_r == '0) [*6]) else $error("taken too early");
    AST_REQ_STICKY: assert property (@(posedge core_clk) disable iff (!resetn)
        src_req != '0 |=> (request_flag & $past(src_req)) == $past(src_req)) else $error("request lost");
    AST_TRAP_ALWAYS: assert property (@(posedge core_clk) disable iff (!resetn)
        instr_boundary && trap_op && !div_busy && !svc_busy |=> take_r && trap_r) else $error("trap not taken");

endmodule

// *** test/via_seq_model.sv ***
// behavioural instruction sequencer facing the acknowledge block
`timescale 1ns/100ps

module via_seq_model (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic svc_busy,
    input wire logic slow,
    input wire logic hold_next,
    input wire logic trap_next,
    input wire logic vector_load_en,
    input wire logic [15:0] vector_addr,
    output logic instr_boundary,
    output logic instr_hold,
    output logic trap_op,
    output logic [15:0] cur_pc
);
    logic [1:0] cnt_r;

    // one instruction ends per cycle, or one per four when slow; it stalls while servicing runs
    always_ff @(negedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_r <= 2'h0;
            instr_boundary <= 1'b0;
            cur_pc <= 16'h0100;
        end else begin
            cnt_r <= cnt_r + 2'h1;
            instr_boundary <= !svc_busy && (!slow || cnt_r == 2'h3);
            if (vector_load_en) begin
                cur_pc <= vector_addr;
            end else if (instr_boundary) begin
                cur_pc <= cur_pc + 16'h0002;
            end
        end
    end

    // the kind of instruction only means something on a real boundary
    assign instr_hold = instr_boundary & hold_next;
    assign trap_op = instr_boundary & trap_next;
endmodule

// *** test/testbench.sv ***
// self-checking bench for the vectored interrupt acknowledge block
`timescale 1ns/100ps
`include "via_params.svh"

module testbench;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic core_clk, resetn, flag_wr_en, psw_wr_en, psw_restore_en, enable_all_op, mask_all_op, trap_op;
    logic instr_boundary, instr_hold, div_busy, svc_busy, take_pulse, take_is_trap;
    logic stack_push_en, stack_push_is_pc, vector_load_en, slow, hold_next, trap_next;
    logic [15:0] src_req, flag_wr_mask, flag_wr_data, cur_pc, stack_push_data, vector_addr;
    logic [15:0] request_flag, mask_flag, level_select_flag;
    logic [7:0] psw_wr_mask, psw_wr_data, psw_restore_data, processor_status_word;
    logic [1:0] flag_wr_sel;
    logic [3:0] take_index;
    int error_cnt = 0;
    int compares = 0;
    typedef struct packed {
        logic [15:0] req;
        logic [15:0] lvl;
        logic [3:0] idx;
        logic slw;
    } via_row_t;
    // requests, level flags, expected winner, slow sequencer
    via_row_t rows [5] = '{
        '{16'h0001, 16'h0000, 4'h0, 1'b0},
        '{16'h0008, 16'hffff, 4'h3, 1'b1},
        '{16'h0012, 16'hffef, 4'h4, 1'b0},
        '{16'h0024, 16'h0000, 4'h2, 1'b1},
        '{16'h8000, 16'hffff, 4'hf, 1'b0}
    };

    via_top i_dut (.core_clk(core_clk), .resetn(resetn), .src_req(src_req), .flag_wr_en(flag_wr_en),
        .flag_wr_sel(flag_wr_sel), .flag_wr_mask(flag_wr_mask), .flag_wr_data(flag_wr_data),
        .psw_wr_en(psw_wr_en), .psw_wr_mask(psw_wr_mask), .psw_wr_data(psw_wr_data),
        .psw_restore_en(psw_restore_en), .psw_restore_data(psw_restore_data), .enable_all_op(enable_all_op),
        .mask_all_op(mask_all_op), .trap_op(trap_op), .instr_boundary(instr_boundary),
        .instr_hold(instr_hold), .div_busy(div_busy), .cur_pc(cur_pc), .request_flag(request_flag),
        .mask_flag(mask_flag), .level_select_flag(level_select_flag),
        .processor_status_word(processor_status_word), .svc_busy(svc_busy), .take_pulse(take_pulse),
        .take_is_trap(take_is_trap), .take_index(take_index), .stack_push_en(stack_push_en),
        .stack_push_is_pc(stack_push_is_pc), .stack_push_data(stack_push_data),
        .vector_load_en(vector_load_en), .vector_addr(vector_addr));

    via_seq_model i_seq (.core_clk(core_clk), .resetn(resetn), .svc_busy(svc_busy), .slow(slow),
        .hold_next(hold_next), .trap_next(trap_next), .vector_load_en(vector_load_en),
        .vector_addr(vector_addr), .instr_boundary(instr_boundary), .instr_hold(instr_hold),
        .trap_op(trap_op), .cur_pc(cur_pc));

    // clock at 100 MHz
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic close_out();
        if (error_cnt == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic check1(input logic seen, input logic exp);
        check({15'h0000, seen}, {15'h0000, exp});
    endtask

    // flag writes last one cycle and are released on the next falling edge
    task automatic wr_flags(input logic [1:0] sel, input logic [15:0] msk, input logic [15:0] dat);
        @(negedge core_clk);
        flag_wr_en <= 1'b1;
        flag_wr_sel <= sel;
        flag_wr_mask <= msk;
        flag_wr_data <= dat;
        @(negedge core_clk);
        flag_wr_en <= 1'b0;
    endtask

    // one instruction acting on the status word: enable-all, mask-all or a return
    task automatic psw_op(input logic ea, input logic ma, input logic rs, input logic [7:0] dat, input logic hld);
        @(negedge core_clk);
        enable_all_op <= ea;
        mask_all_op <= ma;
        psw_restore_en <= rs;
        psw_restore_data <= dat;
        hold_next <= hld;
        @(negedge core_clk);
        enable_all_op <= 1'b0;
        mask_all_op <= 1'b0;
        psw_restore_en <= 1'b0;
        hold_next <= 1'b0;
    endtask

    // nothing may be taken for n cycles
    task automatic quiet(input int n);
        repeat (n) begin
            @(negedge core_clk);
            src_req <= '0;
            check1(take_pulse, 1'b0);
        end
    endtask

    // wait for a take, then follow the three-cycle stacking walk
    task automatic serve(input logic trp, input logic [3:0] idx, input int lo, input int hi,
                         input logic [7:0] psw0, input logic in_service_level_flag);
        int lat;
        logic [15:0] pc0;
        // counted from the falling edge that raised the request, so lat equals clocks to the take
        lat = 0;
        do begin
            @(negedge core_clk);
            src_req <= '0;
            trap_next <= 1'b0;
            lat++;
        end while (take_pulse !== 1'b1 && lat < 80);
        pc0 = cur_pc;
        check1(lat >= lo && lat <= hi, 1'b1);
        check1(stack_push_en & ~stack_push_is_pc, 1'b1);
        check(stack_push_data, {8'h00, psw0});
        check({8'h00, processor_status_word}, {8'h00, 1'b0, psw0[6:2], in_service_level_flag, psw0[0]});
        @(negedge core_clk);
        check1(stack_push_en & stack_push_is_pc, 1'b1);
        check(stack_push_data, pc0);
        @(negedge core_clk);
        check1(vector_load_en & (take_is_trap === trp), 1'b1);
        check(vector_addr, trp ? `VIA_TRAP_VECTOR : `VIA_VEC_BASE + {11'h000, idx, 1'b0});
        if (!trp) begin
            check({12'h000, take_index}, {12'h000, idx});
        end
        @(negedge core_clk);
        check1(svc_busy, 1'b0);
    endtask

    // watchdog far beyond the few hundred cycles the run needs
    initial begin
        #200000;
        error_cnt++;
        close_out();
    end

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        logic lv;
        {src_req, flag_wr_en, flag_wr_sel, flag_wr_mask, flag_wr_data} = '0;
        {psw_wr_en, psw_wr_mask, psw_wr_data, psw_restore_en, psw_restore_data} = '0;
        {enable_all_op, mask_all_op, div_busy, slow, hold_next, trap_next} = '0;
        resetn = 1'b0;
        repeat (6) @(posedge core_clk);
        @(negedge core_clk);
        resetn <= 1'b1;
        // ordinary takes: latency window, priority pick, stacking order
        foreach (rows[i]) begin
            wr_flags(`VIA_SEL_LEVEL, 16'hffff, rows[i].lvl);
            wr_flags(`VIA_SEL_MASK, 16'hffff, ~rows[i].req);
            psw_op(1'b1, 1'b0, 1'b0, 8'h00, 1'b1);
            @(negedge core_clk);
            slow <= rows[i].slw;
            src_req <= rows[i].req;
            lv = rows[i].lvl[rows[i].idx];
            serve(1'b0, rows[i].idx, lv ? `VIA_MIN_LAT_LOW : `VIA_MIN_LAT_HIGH,
                  lv ? `VIA_MAX_LAT_LOW : `VIA_MAX_LAT_HIGH, 8'h82, lv);
            check1(request_flag[rows[i].idx], 1'b1);
            slow <= 1'b0;
            psw_op(1'b0, 1'b0, 1'b1, 8'h02, 1'b1);
            wr_flags(`VIA_SEL_REQUEST, 16'hffff, 16'h0000);
        end
        // reset in mid-run brings every flag back
        @(negedge core_clk);
        resetn <= 1'b0;
        @(negedge core_clk);
        check(mask_flag, 16'hffff);
        check(level_select_flag, 16'hffff);
        check({request_flag[7:0], processor_status_word}, {8'h00, `VIA_PSW_RESET});
        resetn <= 1'b1;
        // a masked request waits; selector 3 writes nothing
        @(negedge core_clk);
        psw_wr_en <= 1'b1;
        psw_wr_mask <= 8'h80;
        psw_wr_data <= 8'h80;
        src_req <= 16'h0080;
        @(negedge core_clk);
        psw_wr_en <= 1'b0;
        quiet(20);
        wr_flags(2'h3, 16'hffff, 16'h0000);
        check(mask_flag, 16'hffff);
        wr_flags(`VIA_SEL_MASK, 16'h0080, 16'h0000);
        serve(1'b0, 4'h7, 0, 80, 8'h82, 1'b1);
        // clear the served flag, else enable-all below would take it again
        wr_flags(`VIA_SEL_REQUEST, 16'hffff, 16'h0000);
        // accept flag off, then held by hold instructions
        psw_op(1'b1, 1'b0, 1'b0, 8'h00, 1'b1);
        check({8'h00, processor_status_word}, 16'h0082);
        psw_op(1'b0, 1'b1, 1'b0, 8'h00, 1'b1);
        check({8'h00, processor_status_word}, 16'h0002);
        wr_flags(`VIA_SEL_MASK, 16'hffff, 16'hff7b);
        @(negedge core_clk);
        src_req <= 16'h0004;
        quiet(40);
        enable_all_op <= 1'b1;
        hold_next <= 1'b1;
        @(negedge core_clk);
        enable_all_op <= 1'b0;
        quiet(3);
        hold_next <= 1'b0;
        serve(1'b0, 4'h2, 0, 80, 8'h82, 1'b1);
        // a running divide delays the take
        psw_op(1'b0, 1'b0, 1'b1, 8'h02, 1'b1);
        wr_flags(`VIA_SEL_REQUEST, 16'hffff, 16'h0000);
        wr_flags(`VIA_SEL_MASK, 16'hffff, 16'hffdc);
        wr_flags(`VIA_SEL_LEVEL, 16'hffff, 16'hfffc);
        psw_op(1'b1, 1'b0, 1'b0, 8'h00, 1'b1);
        @(negedge core_clk);
        src_req <= 16'h0001;
        div_busy <= 1'b1;
        quiet(40);
        div_busy <= 1'b0;
        serve(1'b0, 4'h0, 0, 80, 8'h82, 1'b0);
        // handler clears its own flag so it cannot nest on itself after enable-all
        wr_flags(`VIA_SEL_REQUEST, 16'h0001, 16'h0000);
        // nesting inside a high priority handler
        @(negedge core_clk);
        src_req <= 16'h0020;
        quiet(10);
        psw_op(1'b1, 1'b0, 1'b0, 8'h00, 1'b1);
        quiet(20);
        @(negedge core_clk);
        src_req <= 16'h0002;
        serve(1'b0, 4'h1, 0, 80, 8'h80, 1'b0);
        wr_flags(`VIA_SEL_REQUEST, 16'h0003, 16'h0000);
        psw_op(1'b0, 1'b0, 1'b1, 8'h80, 1'b1);
        quiet(20);
        psw_op(1'b0, 1'b0, 1'b1, 8'h82, 1'b1);
        check1(take_pulse, 1'b0);
        serve(1'b0, 4'h5, 0, 80, 8'h82, 1'b1);
        // trap with the accept flag off, pending request stays out
        psw_op(1'b0, 1'b0, 1'b1, 8'h02, 1'b1);
        wr_flags(`VIA_SEL_REQUEST, 16'hffff, 16'h0000);
        @(negedge core_clk);
        src_req <= 16'h0001;
        quiet(10);
        trap_next <= 1'b1;
        serve(1'b1, 4'h0, 0, 80, 8'h02, 1'b1);
        quiet(20);
        close_out();
    end
endmodule
